// [src/fpsc_consts.svh]
`ifndef FPSC_CONSTS_SVH
`define FPSC_CONSTS_SVH
`define FPSC_ADDR_W      13
`define FPSC_PAGE_LSB    9
`define FPSC_PAGE_MSB    12
`define FPSC_LOCK_ADDR   13'h1dff
`define FPSC_RSV_LO      13'h1e00
`define FPSC_RSV_HI      13'h1fff
`define FPSC_LOCK_ERASED 8'hff
`define FPSC_IRQ_N       8
`endif

// [src/fpsc_pkg.sv]
`default_nettype none
package fpsc_pkg;
  typedef enum logic [1:0] {
    FPSC_OP_READ  = 2'b00,
    FPSC_OP_WRITE = 2'b01,
    FPSC_OP_ERASE = 2'b10
  } fpsc_op_e;

  typedef enum logic [1:0] {
    FPSC_RG_UNLOCKED  = 2'b00,
    FPSC_RG_LOCKED    = 2'b01,
    FPSC_RG_LOCK_PAGE = 2'b10,
    FPSC_RG_RESERVED  = 2'b11
  } fpsc_region_e;

  typedef enum logic [1:0] {
    FPSC_V_ALLOW  = 2'b00,
    FPSC_V_IGNORE = 2'b01,
    FPSC_V_ERROR  = 2'b10
  } fpsc_verdict_e;
endpackage
`default_nettype wire

// [src/fpsc_cls_if.sv]
`include "fpsc_consts.svh"
`default_nettype none
interface fpsc_cls_if;
  logic [`FPSC_ADDR_W-1:0] req_addr;
  logic [`FPSC_ADDR_W-1:0] fetch_addr;
  logic [7:0]              lock_val;
  fpsc_pkg::fpsc_region_e  region;
  logic                    fw_locked;
  logic                    any_locked;

  modport user (output req_addr, fetch_addr, lock_val, input region, fw_locked, any_locked);
  modport cls  (input req_addr, fetch_addr, lock_val, output region, fw_locked, any_locked);
endinterface
`default_nettype wire

// [src/fpsc_classify.sv]
`include "fpsc_consts.svh"
`default_nettype none
module fpsc_classify (
  fpsc_cls_if.cls cls
);
  localparam logic [`FPSC_ADDR_W-1:0] LOCK_PAGE_BASE =
    `FPSC_LOCK_ADDR & ~((`FPSC_ADDR_W'(1) << `FPSC_PAGE_LSB) - `FPSC_ADDR_W'(1));

  // Page count is the inverse of the lock byte, pages counted up from zero
  function automatic logic page_locked(input logic [`FPSC_ADDR_W-1:0] a,
                                       input logic [7:0] lock);
    logic [7:0] page;
    page = {4'h0, a[`FPSC_PAGE_MSB:`FPSC_PAGE_LSB]};
    page_locked = page < ~lock;
  endfunction

  function automatic logic in_lock_page(input logic [`FPSC_ADDR_W-1:0] a);
    in_lock_page = a[`FPSC_PAGE_MSB:`FPSC_PAGE_LSB]
                   == LOCK_PAGE_BASE[`FPSC_PAGE_MSB:`FPSC_PAGE_LSB];
  endfunction

  always_comb begin
    cls.any_locked = cls.lock_val != `FPSC_LOCK_ERASED;
    // Lock page counts as locked once any page is, so it runs protected code too
    cls.fw_locked  = page_locked(cls.fetch_addr, cls.lock_val)
                     || (in_lock_page(cls.fetch_addr) && cls.any_locked);
    if (cls.req_addr >= `FPSC_RSV_LO && cls.req_addr <= `FPSC_RSV_HI) begin
      cls.region = fpsc_pkg::FPSC_RG_RESERVED;
    end else if (in_lock_page(cls.req_addr)) begin
      cls.region = fpsc_pkg::FPSC_RG_LOCK_PAGE;
    end else if (page_locked(cls.req_addr, cls.lock_val)) begin
      cls.region = fpsc_pkg::FPSC_RG_LOCKED;
    end else begin
      cls.region = fpsc_pkg::FPSC_RG_UNLOCKED;
    end
  end
endmodule
`default_nettype wire

// [src/fpsc_checker.sv]
// Functional notes
// - Unlocked ordinary pages are open to debug port and all firmware.
// - Locked pages: debug ignored, unlocked-page firmware resets, locked-page firmware allowed.
// - With no locks, lock page and lock byte reads/writes open to everyone.
// - With locks, lock page access: debug ignored, unlocked firmware resets, locked allowed.
// - No locks: debug may erase lock page; firmware erasing it resets.
// - With locks, only debug device erase clears lock page; firmware erase resets.
// - Changing a written lock byte: debug ignored, firmware resets.
// - Reserved area access: debug ignored, firmware resets.
// - Debug device erase wipes all pages, clearing every lock.
// - Prohibited firmware access resets device; flash error flag reads one afterwards.
// - Prohibited debug operations are ignored and never reset the device.
// - Any locked page also locks the lock byte page.
// - Written lock byte changes only through debug device erase.
// - Firmware lock byte writes act after next reset; protection sampled at reset.
// - Interrupts during flash write/erase stay pending, then served by priority.
// - Locked page count is inverse of lock byte, 512-byte pages from zero.
// - Lock byte is last user flash byte; its page is special.
// - Addresses 0x1E00 to 0x1FFF form the reserved area.
`include "fpsc_consts.svh"
`default_nettype none
module fpsc_checker (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     req_valid_i,
  input  wire logic                     req_debug_i,
  input  wire logic [1:0]               req_op_i,
  input  wire logic [`FPSC_ADDR_W-1:0]  req_addr_i,
  input  wire logic [`FPSC_ADDR_W-1:0]  fetch_addr_i,
  input  wire logic [7:0]               flash_lock_byte_i,
  input  wire logic                     device_erase_i,
  input  wire logic                     flash_busy_i,
  input  wire logic                     irq_enable_i,
  input  wire logic [`FPSC_IRQ_N-1:0]   irq_i,
  input  wire logic [`FPSC_IRQ_N-1:0]   irq_ack_i,
  output logic                          ready_o,
  output logic                          grant_o,
  output logic                          ignore_o,
  output logic                          flash_error_reset_o,
  output logic                          flash_error_flag_o,
  output logic                          erase_all_o,
  output logic [7:0]                    active_lock_o,
  output logic [`FPSC_IRQ_N-1:0]        irq_req_o
);
  fpsc_cls_if cls ();

  logic                        load_pend;
  logic [7:0]                  prot_lock;
  logic [`FPSC_IRQ_N-1:0]      irq_pend;
  fpsc_pkg::fpsc_verdict_e     verdict;
  logic                        take;
  logic                        lock_byte_wr;
  logic                        lock_written;
  logic                        in_reset;
  logic                        take_allow;
  logic                        take_ignore;
  logic                        take_error;
  logic [`FPSC_IRQ_N-1:0]      irq_left;

  assign cls.req_addr   = req_addr_i;
  assign cls.fetch_addr = fetch_addr_i;
  assign cls.lock_val   = prot_lock;

  fpsc_classify u_cls (
    .cls (cls)
  );

  function automatic logic [`FPSC_IRQ_N-1:0] lowest_one(input logic [`FPSC_IRQ_N-1:0] v);
    lowest_one = v & (~v + `FPSC_IRQ_N'(1));
  endfunction

  // Debug port never resets the device; firmware does
  function automatic fpsc_pkg::fpsc_verdict_e refuse(input logic debug);
    refuse = debug ? fpsc_pkg::FPSC_V_IGNORE : fpsc_pkg::FPSC_V_ERROR;
  endfunction

  // Protection follows the lock byte as seen at reset, not live writes
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      load_pend <= 1'b1;
    end else begin
      load_pend <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      prot_lock <= 8'h00;
    end else if (load_pend) begin
      prot_lock <= flash_lock_byte_i;
    end else if (device_erase_i && req_debug_i) begin
      prot_lock <= `FPSC_LOCK_ERASED;
    end
  end

  // Locked until loaded: a one-cycle blackout is cheaper than a leak
  assign take = req_valid_i && !load_pend && !flash_error_reset_o;
  assign lock_byte_wr = req_op_i == fpsc_pkg::FPSC_OP_WRITE && req_addr_i == `FPSC_LOCK_ADDR;
  assign lock_written = flash_lock_byte_i != `FPSC_LOCK_ERASED;
  assign take_allow   = take && verdict == fpsc_pkg::FPSC_V_ALLOW;
  assign take_ignore  = take && verdict == fpsc_pkg::FPSC_V_IGNORE;
  assign take_error   = take && verdict == fpsc_pkg::FPSC_V_ERROR;

  always_comb begin
    verdict = fpsc_pkg::FPSC_V_ALLOW;
    unique case (cls.region)
      fpsc_pkg::FPSC_RG_RESERVED: begin
        verdict = refuse(req_debug_i);
      end
      fpsc_pkg::FPSC_RG_LOCKED: begin
        if (req_debug_i) begin
          verdict = fpsc_pkg::FPSC_V_IGNORE;
        end else if (!cls.fw_locked) begin
          verdict = fpsc_pkg::FPSC_V_ERROR;
        end
      end
      fpsc_pkg::FPSC_RG_LOCK_PAGE: begin
        if (req_op_i == fpsc_pkg::FPSC_OP_ERASE) begin
          if (!req_debug_i) begin
            verdict = fpsc_pkg::FPSC_V_ERROR;
          end else if (cls.any_locked) begin
            verdict = fpsc_pkg::FPSC_V_IGNORE;
          end
        end else if (lock_byte_wr && lock_written) begin
          verdict = refuse(req_debug_i);
        end else if (cls.any_locked) begin
          if (req_debug_i) begin
            verdict = fpsc_pkg::FPSC_V_IGNORE;
          end else if (!cls.fw_locked) begin
            verdict = fpsc_pkg::FPSC_V_ERROR;
          end
        end
      end
      fpsc_pkg::FPSC_RG_UNLOCKED: verdict = fpsc_pkg::FPSC_V_ALLOW;
    endcase
    if (req_op_i == 2'b11) begin
      verdict = refuse(req_debug_i);
    end
    if (req_debug_i && verdict == fpsc_pkg::FPSC_V_ERROR) begin
      verdict = fpsc_pkg::FPSC_V_IGNORE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      grant_o  <= 1'b0;
      ignore_o <= 1'b0;
    end else begin
      grant_o  <= take_allow;
      ignore_o <= take_ignore;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= !load_pend;
    end
  end

  // A long reset must not wash out the flag, so only its first edge captures
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= 1'b0;
    end
  end

  // Request held until the reset arrives; the flag remembers it across that reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      flash_error_reset_o <= 1'b0;
    end else if (take_error) begin
      flash_error_reset_o <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i && !in_reset) begin
      flash_error_flag_o <= flash_error_reset_o;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      erase_all_o <= 1'b0;
    end else begin
      erase_all_o <= device_erase_i && req_debug_i && !load_pend;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      active_lock_o <= 8'h00;
    end else begin
      active_lock_o <= prot_lock;
    end
  end

  // Set wins over acknowledge so no request is lost
  assign irq_left = irq_pend & ~irq_ack_i;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_pend <= '0;
    end else begin
      irq_pend <= irq_left | irq_i;
    end
  end

  // Held back while the flash is busy; pending bits keep waiting
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_req_o <= '0;
    end else if (!flash_busy_i && irq_enable_i) begin
      irq_req_o <= lowest_one(irq_left);
    end else begin
      irq_req_o <= '0;
    end
  end
endmodule
`default_nettype wire

// [test/fpsc_checker_sva.sv]
`include "fpsc_consts.svh"
`default_nettype none
module fpsc_checker_sva (
  input wire logic                    sys_clk_i,
  input wire logic                    rst_n_i,
  input wire logic                    req_valid_i,
  input wire logic                    req_debug_i,
  input wire logic [1:0]              req_op_i,
  input wire logic [`FPSC_ADDR_W-1:0] req_addr_i,
  input wire logic                    device_erase_i,
  input wire logic                    flash_busy_i,
  input wire logic                    ready_o,
  input wire logic                    grant_o,
  input wire logic                    ignore_o,
  input wire logic                    flash_error_reset_o,
  input wire logic                    erase_all_o,
  input wire logic [7:0]              active_lock_o,
  input wire logic [7:0]              irq_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic tk, rsv, lkp;
  // Skip cycles where a device erase moves the lock state under us
  assign tk  = req_valid_i && ready_o && !flash_error_reset_o && !erase_all_o && !device_erase_i;
  assign rsv = req_addr_i >= `FPSC_RSV_LO;
  assign lkp = req_addr_i[12:9] == 4'he;
  open_grant_a: assert property (tk && active_lock_o == 8'hff && !rsv &&
    req_op_i != 2'h3 && !(lkp && req_op_i == 2'h2 && !req_debug_i) &&
    !(req_addr_i == `FPSC_LOCK_ADDR && req_op_i == 2'h1) |=> grant_o)
    else $error("open access not granted");
  single_answer_a: assert property (tk |=> $onehot({grant_o, ignore_o, flash_error_reset_o}))
    else $error("request without exactly one answer");
  fw_rsv_err_a: assert property (tk && !req_debug_i && rsv |=> flash_error_reset_o)
    else $error("reserved firmware access kept running");
  dbg_rsv_ign_a: assert property (tk && req_debug_i && rsv |=> ignore_o)
    else $error("reserved debug access not ignored");
  dbg_no_err_a: assert property (tk && req_debug_i |=> !flash_error_reset_o)
    else $error("debug access caused error reset");
  fw_lkp_erase_a: assert property (tk && !req_debug_i && lkp && req_op_i == 2'h2
    |=> flash_error_reset_o) else $error("firmware lock page erase not trapped");
  err_hold_a: assert property (flash_error_reset_o |=> flash_error_reset_o)
    else $error("error reset request dropped");
  dev_erase_a: assert property (ready_o && device_erase_i && req_debug_i &&
    !flash_error_reset_o |=> erase_all_o ##1 active_lock_o == 8'hff)
    else $error("device erase did not clear locks");
  irq_busy_a: assert property (flash_busy_i |=> irq_req_o == 8'h00)
    else $error("interrupt served during flash operation");
  cover property (tk ##1 grant_o);
  cover property (tk ##1 ignore_o);
  cover property (erase_all_o);
endmodule
bind fpsc_checker fpsc_checker_sva chk_u (.sys_clk_i, .rst_n_i, .req_valid_i, .req_debug_i,
  .req_op_i, .req_addr_i, .device_erase_i, .flash_busy_i, .ready_o, .grant_o, .ignore_o,
  .flash_error_reset_o, .erase_all_o, .active_lock_o, .irq_req_o);
`default_nettype wire

// [test/fpsc_flash_model.sv]
`default_nettype none
module fpsc_flash_model (
  input  wire logic       sys_clk_i,
  input  wire logic       erase_all_i,
  input  wire logic       prog_i,
  input  wire logic [7:0] prog_val_i,
  output var  logic [7:0] lock_byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lock_byte_o = 8'hff;
  // Programming only clears bits, like the real array
  always @(posedge sys_clk_i) begin
    if (erase_all_i) lock_byte_o <= 8'hff;
    else if (prog_i) lock_byte_o <= lock_byte_o & prog_val_i;
  end
endmodule
`default_nettype wire

// [test/tb_flash_page_security_checker.sv]
`default_nettype none
module tb_flash_page_security_checker;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] lk; logic d; logic [1:0] o; logic [12:0] a; logic [12:0] f; logic [2:0] e;
  } fpsc_row_s;
  logic sys_clk_i, rst_n_i = 0, req_valid_i = 0, req_debug_i = 0, device_erase_i = 0;
  logic flash_busy_i = 0, irq_enable_i = 0, blank = 0, prog = 0;
  logic [1:0] req_op_i = 0;
  logic [12:0] req_addr_i = 0, fetch_addr_i = 0;
  logic [7:0] flash_lock_byte_i, irq_i = 0, irq_ack_i = 0, pval = 0, active_lock_o, irq_req_o;
  logic ready_o, grant_o, ignore_o, flash_error_reset_o, flash_error_flag_o, erase_all_o;
  int fails = 0, checks_done = 0;
  // Expected answer is {grant, ignore, error}
  fpsc_row_s rows [14] = '{
    '{8'hff, 0, 0, 13'h0000, 13'h0400, 3'b100}, '{8'hff, 1, 1, 13'h1dff, 0, 3'b100},
    '{8'hff, 1, 2, 13'h1c00, 0, 3'b100}, '{8'hff, 0, 2, 13'h1c00, 0, 3'b001},
    '{8'hfd, 1, 0, 13'h0200, 0, 3'b010}, '{8'hfd, 0, 0, 13'h0200, 13'h0800, 3'b001},
    '{8'hfd, 0, 1, 13'h0300, 13'h0100, 3'b100}, '{8'hfd, 0, 0, 13'h1dff, 0, 3'b100},
    '{8'hfd, 1, 0, 13'h1dff, 0, 3'b010}, '{8'hfd, 0, 2, 13'h1c00, 0, 3'b001},
    '{8'hfd, 1, 1, 13'h1dff, 0, 3'b010}, '{8'hff, 1, 0, 13'h1fff, 0, 3'b010},
    '{8'hfd, 0, 0, 13'h0400, 13'h0400, 3'b100}, '{8'hff, 0, 0, 13'h1e00, 0, 3'b001}};
  fpsc_checker dut_u (.sys_clk_i, .rst_n_i, .req_valid_i, .req_debug_i, .req_op_i, .req_addr_i,
    .fetch_addr_i, .flash_lock_byte_i, .device_erase_i, .flash_busy_i, .irq_enable_i, .irq_i,
    .irq_ack_i, .ready_o, .grant_o, .ignore_o, .flash_error_reset_o, .flash_error_flag_o,
    .erase_all_o, .active_lock_o, .irq_req_o);
  fpsc_flash_model flash_u (.sys_clk_i, .erase_all_i(erase_all_o | blank), .prog_i(prog),
    .prog_val_i(pval), .lock_byte_o(flash_lock_byte_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic ok);
    checks_done++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t check %0d mismatch", $time, checks_done);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask
  // Protection is sampled only at reset, so every lock byte write needs one
  task automatic rst_dut();
    rst_n_i = 1'b0;
    repeat (10) tick();
    rst_n_i = 1'b1;
    repeat (3) tick();
  endtask
  task automatic set_lock(input logic [7:0] v);
    irq_enable_i = 1'b0;
    blank = 1'b1;
    tick();
    blank = 1'b0;
    prog = 1'b1;
    pval = v;
    tick();
    prog = 1'b0;
  endtask
  task automatic req(input logic d, input logic [1:0] o, input logic [12:0] a, f);
    req_debug_i = d;
    req_op_i = o;
    req_addr_i = a;
    fetch_addr_i = f;
    req_valid_i = 1'b1;
    tick();
    req_valid_i = 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    stop_test();
  end
  initial begin
    #1;
    rst_dut();
    chk(ready_o === 1'b1 && active_lock_o === 8'hff);
    foreach (rows[i]) begin
      set_lock(rows[i].lk);
      rst_dut();
      req(rows[i].d, rows[i].o, rows[i].a, rows[i].f);
      chk({grant_o, ignore_o, flash_error_reset_o} === rows[i].e);
    end
    rst_dut();
    chk(flash_error_flag_o === 1'b1);
    rst_dut();
    chk(flash_error_flag_o === 1'b0);
    set_lock(8'hfd);
    rst_dut();
    chk(active_lock_o === 8'hfd);
    req_debug_i = 1'b1;
    device_erase_i = 1'b1;
    tick();
    device_erase_i = 1'b0;
    chk(erase_all_o === 1'b1);
    tick();
    chk(active_lock_o === 8'hff);
    prog = 1'b1;
    pval = 8'hfe;
    tick();
    prog = 1'b0;
    repeat (3) tick();
    chk(active_lock_o === 8'hff);
    rst_dut();
    chk(active_lock_o === 8'hfe);
    irq_enable_i = 1'b1;
    flash_busy_i = 1'b1;
    irq_i = 8'h0a;
    tick();
    irq_i = 8'h00;
    repeat (3) tick();
    chk(irq_req_o === 8'h00);
    flash_busy_i = 1'b0;
    repeat (2) tick();
    chk(irq_req_o === 8'h02);
    irq_ack_i = 8'h02;
    tick();
    irq_ack_i = 8'h00;
    tick();
    chk(irq_req_o === 8'h08);
    stop_test();
  end
endmodule
`default_nettype wire
